// file: common/swrt_pkg.sv
// Constants and types shared by the watchdog reset timer
package swrt_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Configuration port pair
   localparam logic [15:0] IDX_PORT = 16'h002E;
   localparam logic [15:0] DATA_PORT = 16'h002F;
   localparam logic [7:0] UNLOCK_KEY = 8'h87;
   localparam logic [7:0] LOCK_KEY = 8'hAA;
   localparam logic [7:0] LOCKED_READ = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // Register indices
   localparam logic [7:0] IDX_LDN = 8'h07;
   localparam logic [7:0] IDX_ROUTE = 8'h2D;
   localparam logic [7:0] IDX_ACT = 8'h30;
   localparam logic [7:0] IDX_UNIT = 8'hF5;
   localparam logic [7:0] IDX_COUNT = 8'hF6;

   ////////////////////////////////////////////////////////////////////////
   // Field values and positions
   localparam logic [7:0] WDG_LDN = 8'h08;
   localparam logic [7:0] ACT_ON = 8'h01;
   localparam logic [7:0] ACT_OFF = 8'h00;
   localparam int ACT_BIT = 0;
   localparam logic [7:0] UNIT_SEC = 8'h00;
   localparam logic [7:0] UNIT_MIN = 8'h08;
   localparam int UNIT_MIN_BIT = 3;
   localparam logic [7:0] COUNT_OFF = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Values after reset
   localparam logic [7:0] RST_INDEX = 8'h00;
   localparam logic [7:0] RST_LDN = 8'h00;
   localparam logic [7:0] RST_ROUTE = 8'h00;
   localparam logic [7:0] RST_UNIT = 8'h00;
   localparam logic [7:0] RST_COUNT = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int UNIT_SEC_NS = 1000000000;
   localparam int SEC_CYCLES = UNIT_SEC_NS / CLK_PERIOD_NS;
   localparam int MIN_SECONDS = 60;
   localparam int RST_PULSE_NS = 1000;
   localparam int RST_PULSE_CYCLES =
      (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRE_W = 27;
   localparam int MIN_W = 6;
   localparam int PULSE_W = 8;

   ////////////////////////////////////////////////////////////////////////
   // Configuration lock states
   typedef enum logic [2:0] {
      LOCKED = 3'b001,
      HALF_OPEN = 3'b010,
      CFG_OPEN = 3'b100
   } swrt_lock_t;

endpackage

// file: core/swrt_tick_gen.sv
// Time base: one pulse per second or per minute
`timescale 1ns/10ps
module swrt_tick_gen #(
   parameter int SEC_CYCLES_P = swrt_pkg::SEC_CYCLES
) (
   // Clock and reset
   input logic mclk,
   input logic srst,
   // Control
   input logic restart,
   input logic run,
   input logic minuteMode,
   // Time base
   output logic unitTick
);
   import swrt_pkg::*;

   logic [PRE_W-1:0] preCnt_r;
   logic [MIN_W-1:0] secCnt_r;
   logic secEnd;
   logic minEnd;

   assign secEnd = (preCnt_r == PRE_W'(SEC_CYCLES_P - 1));
   assign minEnd = (secCnt_r == MIN_W'(MIN_SECONDS - 1));

   ////////////////////////////////////////////////////////////////////////
   // Cycle prescaler
   always_ff @(posedge mclk) begin
      if (srst || restart || !run) begin
         preCnt_r <= '0;
      end else if (secEnd) begin
         preCnt_r <= '0;
      end else begin
         preCnt_r <= preCnt_r + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Second counter for minute mode
   always_ff @(posedge mclk) begin
      if (srst || restart || !run) begin
         secCnt_r <= '0;
      end else if (secEnd) begin
         secCnt_r <= minEnd ? '0 : secCnt_r + 1'b1;
      end
   end

   assign unitTick = run && !restart && secEnd && (!minuteMode || minEnd);

endmodule

// file: core/swrt_down_counter.sv
// Watchdog countdown in units of the selected time base
`timescale 1ns/10ps
module swrt_down_counter (
   // Clock and reset
   input logic mclk,
   input logic srst,
   // Control
   input logic load,
   input logic [7:0] loadValue,
   input logic stop,
   input logic unitTick,
   // State
   output logic [7:0] remaining,
   output logic expire
);
   import swrt_pkg::*;

   logic [7:0] remain_r;
   logic expire_r;
   logic lastUnit;

   assign lastUnit = (remain_r == 8'h01) && unitTick && !load && !stop;

   ////////////////////////////////////////////////////////////////////////
   // Countdown
   always_ff @(posedge mclk) begin
      if (srst || stop) begin
         remain_r <= COUNT_OFF;
      end else if (load) begin
         remain_r <= loadValue;
      end else if (unitTick && remain_r != COUNT_OFF) begin
         remain_r <= remain_r - 8'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Expiry pulse
   always_ff @(posedge mclk) begin
      if (srst) begin
         expire_r <= 1'b0;
      end else begin
         expire_r <= lastUnit;
      end
   end

   assign remaining = remain_r;
   assign expire = expire_r;

endmodule

// file: core/swrt_watchdog.sv
// Watchdog reset timer behind an index/data configuration port pair
`timescale 1ns/10ps
module swrt_watchdog #(
   parameter int SEC_CYCLES_P = swrt_pkg::SEC_CYCLES
) (
   // Clock and reset
   input logic mclk,
   input logic srst,
   // Host I/O cycle
   input logic [15:0] ioAddr,
   input logic [7:0] ioWrData,
   input logic ioWrStb,
   input logic ioRdStb,
   // Host read answer
   output logic [7:0] ioRdData,
   output logic ioRdValid,
   // Watchdog state
   output logic sysReset,
   output logic wdgRunning,
   output logic cfgOpen
);
   import swrt_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   swrt_lock_t lockState_r;
   swrt_lock_t lockState_nxt;
   logic [7:0] index_r;
   logic [7:0] ldn_r;
   logic [7:0] route_r;
   logic active_r;
   logic [7:0] unit_r;
   logic [7:0] count_r;
   logic [7:0] rdData_r;
   logic [7:0] rdData_nxt;
   logic rdValid_r;
   logic sysReset_r;
   logic [PULSE_W-1:0] pulseCnt_r;
   logic running_r;
   logic open_r;
   logic idxWr;
   logic dataWr;
   logic idxRd;
   logic dataRd;
   logic cfgWr;
   logic wdgSel;
   logic actWr;
   logic unitWr;
   logic countWr;
   logic actOnWr;
   logic actOffWr;
   logic loadNow;
   logic [7:0] loadValue;
   logic minuteMode;
   logic unitTick;
   logic [7:0] remaining;
   logic expire;

   ////////////////////////////////////////////////////////////////////////
   // Port decode
   assign idxWr = ioWrStb && (ioAddr == IDX_PORT);
   assign dataWr = ioWrStb && (ioAddr == DATA_PORT);
   assign idxRd = ioRdStb && (ioAddr == IDX_PORT);
   assign dataRd = ioRdStb && (ioAddr == DATA_PORT);

   ////////////////////////////////////////////////////////////////////////
   // Configuration lock
   always_comb begin
      lockState_nxt = lockState_r;
      unique case (lockState_r)
         LOCKED: begin
            if (idxWr && ioWrData == UNLOCK_KEY) begin
               lockState_nxt = HALF_OPEN;
            end
         end
         HALF_OPEN: begin
            if (idxWr) begin
               if (ioWrData == UNLOCK_KEY) begin
                  lockState_nxt = CFG_OPEN;
               end else begin
                  lockState_nxt = LOCKED;
               end
            end else if (dataWr) begin
               lockState_nxt = LOCKED;
            end
         end
         CFG_OPEN: begin
            if (idxWr && ioWrData == LOCK_KEY) begin
               lockState_nxt = LOCKED;
            end
         end
         default: begin
            lockState_nxt = LOCKED;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         lockState_r <= LOCKED;
      end else begin
         lockState_r <= lockState_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Index register
   always_ff @(posedge mclk) begin
      if (srst) begin
         index_r <= RST_INDEX;
      end else if (idxWr && lockState_r == CFG_OPEN &&
                   ioWrData != LOCK_KEY) begin
         index_r <= ioWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Write qualification
   assign cfgWr = dataWr && (lockState_r == CFG_OPEN);
   assign wdgSel = (ldn_r == WDG_LDN);
   assign actWr = cfgWr && wdgSel && (index_r == IDX_ACT);
   assign unitWr = cfgWr && wdgSel && (index_r == IDX_UNIT);
   assign countWr = cfgWr && wdgSel && (index_r == IDX_COUNT);
   assign actOnWr = actWr && ioWrData[ACT_BIT];
   assign actOffWr = actWr && !ioWrData[ACT_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Global registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         ldn_r <= RST_LDN;
      end else if (cfgWr && index_r == IDX_LDN) begin
         ldn_r <= ioWrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         route_r <= RST_ROUTE;
      end else if (cfgWr && index_r == IDX_ROUTE) begin
         route_r <= ioWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog registers
   always_ff @(posedge mclk) begin
      if (srst) begin
         active_r <= ACT_OFF[ACT_BIT];
      end else if (actWr) begin
         active_r <= ioWrData[ACT_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         unit_r <= RST_UNIT;
      end else if (unitWr) begin
         unit_r <= ioWrData;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         count_r <= RST_COUNT;
      end else if (countWr) begin
         count_r <= ioWrData;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Countdown control
   assign minuteMode = unitWr ? ioWrData[UNIT_MIN_BIT] :
                       unit_r[UNIT_MIN_BIT];
   assign loadValue = countWr ? ioWrData : count_r;
   assign loadNow = (active_r && (countWr || unitWr) && !actOffWr) ||
                    (!active_r && actOnWr);

   swrt_tick_gen #(
      .SEC_CYCLES_P(SEC_CYCLES_P)
   ) u_tick (
      .mclk(mclk),
      .srst(srst),
      .restart(loadNow),
      .run(active_r),
      .minuteMode(minuteMode),
      .unitTick(unitTick)
   );

   swrt_down_counter u_count (
      .mclk(mclk),
      .srst(srst),
      .load(loadNow),
      .loadValue(loadValue),
      .stop(actOffWr),
      .unitTick(unitTick),
      .remaining(remaining),
      .expire(expire)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read path
   always_comb begin
      rdData_nxt = LOCKED_READ;
      if (idxRd) begin
         rdData_nxt = (lockState_r == CFG_OPEN) ? index_r : LOCKED_READ;
      end else if (dataRd && lockState_r == CFG_OPEN) begin
         case (index_r)
            IDX_LDN: begin
               rdData_nxt = ldn_r;
            end
            IDX_ROUTE: begin
               rdData_nxt = route_r;
            end
            IDX_ACT: begin
               rdData_nxt = wdgSel ? {7'h00, active_r} : 8'h00;
            end
            IDX_UNIT: begin
               rdData_nxt = wdgSel ? unit_r : 8'h00;
            end
            IDX_COUNT: begin
               rdData_nxt = wdgSel ? remaining : 8'h00;
            end
            default: begin
               rdData_nxt = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= idxRd || dataRd;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdData_r <= 8'h00;
      end else if (idxRd || dataRd) begin
         rdData_r <= rdData_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // System reset pulse
   always_ff @(posedge mclk) begin
      if (srst) begin
         pulseCnt_r <= '0;
      end else if (expire) begin
         pulseCnt_r <= PULSE_W'(RST_PULSE_CYCLES - 1);
      end else if (pulseCnt_r != '0) begin
         pulseCnt_r <= pulseCnt_r - 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         sysReset_r <= 1'b0;
      end else if (expire) begin
         sysReset_r <= 1'b1;
      end else if (pulseCnt_r == '0) begin
         sysReset_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status
   always_ff @(posedge mclk) begin
      if (srst) begin
         running_r <= 1'b0;
      end else begin
         running_r <= active_r && (remaining != COUNT_OFF);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         open_r <= 1'b0;
      end else begin
         open_r <= (lockState_nxt == CFG_OPEN);
      end
   end

   assign ioRdData = rdData_r;
   assign ioRdValid = rdValid_r;
   assign sysReset = sysReset_r;
   assign wdgRunning = running_r;
   assign cfgOpen = open_r;

endmodule

// file: test/swrt_watchdog_checker.sv
// Port-level checks for the watchdog reset timer
`timescale 1ns/10ps
module swrt_watchdog_checker
   import swrt_pkg::*;
(
   // Clock and reset
   input logic mclk,
   input logic srst,
   // Host cycle
   input logic [15:0] ioAddr,
   input logic [7:0] ioWrData,
   input logic ioWrStb,
   input logic ioRdStb,
   input logic [7:0] ioRdData,
   input logic ioRdValid,
   // Watchdog state
   input logic sysReset,
   input logic wdgRunning,
   input logic cfgOpen
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   logic [7:0] pulseLen_r;
   logic portHit;
   assign portHit = ioAddr == IDX_PORT || ioAddr == DATA_PORT;
   always_ff @(posedge mclk) begin
      if (srst || !sysReset)
         pulseLen_r <= 8'h00;
      else
         pulseLen_r <= pulseLen_r + 8'h01;
   end
   ////////////////////////////////////////
   chk_read_answer: assert property (
      ioRdStb && portHit |=> ioRdValid)
      else $error("port read not answered");
   chk_other_port: assert property (
      ioRdStb && !portHit |=> !ioRdValid)
      else $error("foreign address answered");
   chk_rddata_hold: assert property (
      !$past(ioRdStb) |-> $stable(ioRdData))
      else $error("read data moved without a read");
   chk_unlock_key: assert property (
      $rose(cfgOpen) |-> $past(ioWrStb && ioAddr == IDX_PORT
         && ioWrData == UNLOCK_KEY))
      else $error("opened without unlock byte");
   chk_locked_read: assert property (
      !cfgOpen && ioRdStb && portHit |=> ioRdData == LOCKED_READ)
      else $error("locked read not FF");
   chk_run_cause: assert property (
      $rose(wdgRunning) |-> $past(ioWrStb && ioAddr == DATA_PORT)
         || $past(ioWrStb && ioAddr == DATA_PORT, 2))
      else $error("countdown started without a write");
   chk_reset_cause: assert property (
      $rose(sysReset) |-> $past(wdgRunning) || $past(wdgRunning, 2))
      else $error("reset without a running countdown");
   chk_pulse_len: assert property (
      $fell(sysReset) |-> pulseLen_r == 8'(RST_PULSE_CYCLES))
      else $error("reset pulse length wrong");
endmodule

// file: test/tb_swrt_watchdog.sv
// Self-checking bench for the watchdog reset timer
`timescale 1ns/10ps
module tb_swrt_watchdog;
   import swrt_pkg::*;
   localparam int SEC = 10;
   localparam int MIN = SEC * 60;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] ioAddr = 16'h0000;
   logic [7:0] ioWrData = 8'h00;
   logic ioWrStb = 1'b0;
   logic ioRdStb = 1'b0;
   logic [7:0] ioRdData;
   logic ioRdValid;
   logic sysReset;
   logic wdgRunning;
   logic cfgOpen;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   always #5 mclk = ~mclk;
   swrt_watchdog #(.SEC_CYCLES_P(SEC)) i_dut (
      .mclk(mclk), .srst(srst), .ioAddr(ioAddr),
      .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
      .ioRdData(ioRdData), .ioRdValid(ioRdValid),
      .sysReset(sysReset), .wdgRunning(wdgRunning), .cfgOpen(cfgOpen)
   );
   ////////////////////////////////////////
   task automatic end_sim();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      ioAddr = a;
      ioWrData = d;
      ioWrStb = 1'b1;
      @(negedge mclk);
      ioWrStb = 1'b0;
      @(negedge mclk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] d,
      input logic v);
      ioAddr = a;
      ioRdStb = 1'b1;
      @(negedge mclk);
      ioRdStb = 1'b0;
      chk(8'(ioRdValid), 8'(v));
      if (v)
         chk(ioRdData, d);
      @(negedge mclk);
   endtask
   task automatic cfg(input logic [7:0] i, input logic [7:0] d);
      wr(IDX_PORT, i);
      wr(DATA_PORT, d);
   endtask
   task automatic cfgRd(input logic [7:0] i, input logic [7:0] d);
      wr(IDX_PORT, i);
      rd(DATA_PORT, d, 1'b1);
   endtask
   task automatic wait_rst(input int lo, input int hi);
      int n;
      n = 0;
      while (sysReset !== 1'b1 && n <= hi) begin
         @(negedge mclk);
         n++;
      end
      chk(8'(n >= lo && n <= hi), 8'h01);
   endtask
   ////////////////////////////////////////
   task automatic t_lock();
      cfg(IDX_LDN, WDG_LDN);
      rd(DATA_PORT, LOCKED_READ, 1'b1);
      rd(IDX_PORT, LOCKED_READ, 1'b1);
      wr(IDX_PORT, UNLOCK_KEY);
      wr(DATA_PORT, 8'h11);
      wr(IDX_PORT, UNLOCK_KEY);
      chk(8'(cfgOpen), 8'h00);
      wr(IDX_PORT, UNLOCK_KEY);
      chk(8'(cfgOpen), 8'h01);
      cfgRd(IDX_LDN, RST_LDN);
      rd(IDX_PORT, IDX_LDN, 1'b1);
      rd(16'h0080, 8'h00, 1'b0);
      cfg(IDX_ACT, ACT_ON);
      cfgRd(IDX_ACT, 8'h00);
   endtask
   task automatic t_setup();
      cfg(IDX_ROUTE, 8'h20);
      cfg(IDX_LDN, WDG_LDN);
      cfgRd(IDX_ROUTE, 8'h20);
      cfgRd(IDX_LDN, WDG_LDN);
      cfgRd(IDX_UNIT, RST_UNIT);
      cfgRd(IDX_ACT, ACT_OFF);
   endtask
   task automatic t_zero();
      cfg(IDX_COUNT, COUNT_OFF);
      cfg(IDX_ACT, ACT_ON);
      waitc(3 * SEC);
      chk(8'(sysReset | wdgRunning), 8'h00);
      cfg(IDX_UNIT, UNIT_MIN);
      waitc(3 * SEC);
      chk(8'(sysReset | wdgRunning), 8'h00);
      cfg(IDX_UNIT, UNIT_SEC);
   endtask
   task automatic t_sec();
      cfg(IDX_COUNT, 8'h03);
      chk(8'(wdgRunning), 8'h01);
      wait_rst(3 * SEC - 2, 3 * SEC + 4);
      waitc(110);
      chk(8'(sysReset), 8'h00);
      cfgRd(IDX_COUNT, COUNT_OFF);
      cfg(IDX_COUNT, 8'h03);
      waitc(2 * SEC);
      cfg(IDX_COUNT, 8'h03);
      waitc(2 * SEC);
      chk(8'(sysReset), 8'h00);
      wait_rst(SEC - 6, SEC + 4);
      waitc(110);
      cfg(IDX_COUNT, 8'hFF);
      wait_rst(255 * SEC - 2, 255 * SEC + 4);
      waitc(110);
   endtask
   task automatic t_min();
      cfg(IDX_COUNT, 8'h01);
      cfg(IDX_UNIT, UNIT_MIN);
      wait_rst(MIN - 2, MIN + 4);
      waitc(110);
      cfg(IDX_UNIT, UNIT_SEC);
   endtask
   task automatic t_dis();
      cfg(IDX_COUNT, 8'h05);
      waitc(2 * SEC);
      cfg(IDX_ACT, ACT_OFF);
      waitc(6 * SEC);
      chk(8'(sysReset | wdgRunning), 8'h00);
      cfgRd(IDX_COUNT, COUNT_OFF);
      cfg(IDX_COUNT, 8'h02);
      waitc(4 * SEC);
      chk(8'(sysReset), 8'h00);
      cfg(IDX_ACT, ACT_ON);
      wait_rst(2 * SEC - 2, 2 * SEC + 4);
      waitc(110);
   endtask
   task automatic t_rst();
      wr(IDX_PORT, LOCK_KEY);
      chk(8'(cfgOpen), 8'h00);
      cfg(IDX_COUNT, 8'h05);
      chk(8'(wdgRunning), 8'h00);
      wr(IDX_PORT, UNLOCK_KEY);
      wr(IDX_PORT, UNLOCK_KEY);
      chk(8'(cfgOpen), 8'h01);
      rd(IDX_PORT, IDX_ACT, 1'b1);
      cfg(IDX_COUNT, 8'h05);
      waitc(2 * SEC);
      srst = 1'b1;
      waitc(2);
      srst = 1'b0;
      chk(8'(cfgOpen), 8'h00);
      waitc(6 * SEC);
      chk(8'(sysReset | wdgRunning), 8'h00);
      rd(DATA_PORT, LOCKED_READ, 1'b1);
      wr(IDX_PORT, UNLOCK_KEY);
      wr(IDX_PORT, IDX_LDN);
      wr(IDX_PORT, UNLOCK_KEY);
      chk(8'(cfgOpen), 8'h00);
   endtask
   ////////////////////////////////////////
   initial begin
      waitc(8);
      srst = 1'b0;
      t_lock();
      t_setup();
      t_zero();
      t_sec();
      t_min();
      t_dis();
      t_rst();
      end_sim();
   end
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
endmodule
bind swrt_watchdog swrt_watchdog_checker i_chk (
   .mclk(mclk), .srst(srst), .ioAddr(ioAddr),
   .ioWrData(ioWrData), .ioWrStb(ioWrStb), .ioRdStb(ioRdStb),
   .ioRdData(ioRdData), .ioRdValid(ioRdValid),
   .sysReset(sysReset), .wdgRunning(wdgRunning), .cfgOpen(cfgOpen)
);
